// ===== hw/ddo_dimming_out.sv
// Dimming output controller with pwm, sync, reset and sensor buffering
`timescale 1ns/1ps
`default_nettype none
`include "ddo_cfg.svh"
// Overview of operation
// - All timing comes from one on-chip master clock.
// - Dimming input is 10-bit; zero means full dimming, maximum none.
// - Level comes from the analog pin or from network commands.
// - Supply level chooses internal or external input scaling.
// - Pwm outputs have 12-bit duty and 888 Hz period.
// - Three pwm outputs share frequency, edges offset from each other.
// - Primary output is analog level or pwm, 0 to 100 percent.
// - Second and third outputs are pwm tracking the primary level.
// - Strap picks mode: 0 analog primary, 1 pwm primary.
// - Pwm periods can align to an external sync pulse train.
// - Sync pin left open disables sync, outputs free-run.
// - Sync pin low over 100 ms resets the device.
// - Progress indicator is on while programming runs.
// - 16-bit sensor result moves through a double buffer.
// - Auxiliary input senses scaled analog or digital levels.
module ddo_dimming_out #(
    parameter int RESET_CYC = `DDO_RESET_CYC,
    parameter int SYNC_IDLE_CYC = `DDO_SYNC_IDLE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [9:0] dim_level_input,
    input wire logic hv_supply_high,
    input wire logic cmd_level_valid,
    input wire logic [9:0] cmd_level,
    input wire logic cmd_select,
    input wire logic mode_strap,
    input wire logic sync_or_reset_pin,
    input wire logic prog_active,
    input wire logic [15:0] lux_result,
    input wire logic lux_done,
    input wire logic lux_read,
    input wire logic aux_digital_mode,
    input wire logic [9:0] aux_level,
    input wire logic aux_pin,
    output ddo_pkg::ddo_pwm_type pwm_out,
    output ddo_pkg::ddo_stat_type status,
    output logic [9:0] input_scaled,
    output logic scale_external,
    output logic progress_indicator,
    output logic [15:0] lux_data,
    output logic aux_state,
    output logic device_reset
);
    typedef struct packed {
        ddo_pkg::ddo_state_type state;
        logic mode;
        logic [11:0] count;
        logic [4:0] pre;
        logic [9:0] cmd_lvl;
        logic cmd_sel;
        logic [9:0] lvl;
        logic scale_ext;
        logic [11:0] duty;
        logic sync_d;
        logic sync_en;
        logic [31:0] low_cnt;
        logic [31:0] idle_cnt;
        logic dev_rst;
        logic led;
        logic [15:0] lux_hold;
        logic lux_pend;
        logic [15:0] lux_out;
        logic aux;
    } ddo_state_vec_type;

    localparam logic [4:0] PRE_MAX = 5'(`DDO_PWM_PERIOD - 1);
    ddo_state_vec_type st_r;
    ddo_state_vec_type st_nxt;
    ddo_pkg::ddo_pwm_type pwm_w;
    logic tick;
    logic pwm1_en;

    assign tick = (st_r.pre == PRE_MAX); // Divider enable
    assign pwm1_en = st_r.mode && (st_r.state == ddo_pkg::DDO_ST_RUN);

    // Next state of the whole block
    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            ddo_pkg::DDO_ST_STRAP: begin
                st_nxt.mode = mode_strap;
                st_nxt.state = ddo_pkg::DDO_ST_RUN;
            end
            ddo_pkg::DDO_ST_RUN: begin
                if (st_r.low_cnt >= 32'(RESET_CYC)) begin
                    st_nxt.state = ddo_pkg::DDO_ST_RESET;
                end
            end
            ddo_pkg::DDO_ST_RESET: begin
                // Hold reset until the pin is released
                if (sync_or_reset_pin) begin
                    st_nxt = '0;
                    st_nxt.state = ddo_pkg::DDO_ST_STRAP;
                end
            end
            default: st_nxt.state = ddo_pkg::DDO_ST_STRAP;
        endcase
        st_nxt.dev_rst = (st_nxt.state == ddo_pkg::DDO_ST_RESET);

        // Level source: latched command or analog pin
        if (cmd_level_valid) begin
            st_nxt.cmd_lvl = cmd_level;
        end
        st_nxt.cmd_sel = cmd_select;
        st_nxt.lvl = st_r.cmd_sel ? st_r.cmd_lvl : dim_level_input;
        // Zero code is full dimming, so duty scales upward
        st_nxt.duty = {st_r.lvl, st_r.lvl[9:8]};
        st_nxt.scale_ext = !hv_supply_high;

        // Pwm counter, 4096 steps per period
        st_nxt.pre = tick ? 5'h00 : st_r.pre + 5'h01;
        if (tick) begin
            st_nxt.count = st_r.count + 12'h001;
        end

        // Sync: falling pin edge restarts the period once sync is enabled; the first edge only enables it
        st_nxt.sync_d = sync_or_reset_pin;
        if (!sync_or_reset_pin) begin
            st_nxt.low_cnt = st_r.low_cnt + 32'h1;
        end else begin
            st_nxt.low_cnt = '0;
        end
        // Open pin floats high; no edges for a while means no sync
        if (st_r.sync_d && !sync_or_reset_pin) begin
            st_nxt.idle_cnt = '0;
            st_nxt.sync_en = 1'b1;
            if (st_r.sync_en) begin
                st_nxt.count = 12'h000;
                st_nxt.pre = 5'h00;
            end
        end else if (st_r.idle_cnt >= 32'(SYNC_IDLE_CYC)) begin
            st_nxt.sync_en = 1'b0;
        end else begin
            st_nxt.idle_cnt = st_r.idle_cnt + 32'h1;
        end

        st_nxt.led = prog_active;

        // Double buffer: hold then publish when no read in progress
        if (lux_done) begin
            st_nxt.lux_hold = lux_result;
            st_nxt.lux_pend = 1'b1;
        end
        if (st_r.lux_pend && !lux_read) begin
            st_nxt.lux_out = st_r.lux_hold;
            st_nxt.lux_pend = lux_done;
        end

        // Aux: digital pin or threshold at mid scale
        st_nxt.aux = aux_digital_mode ? aux_pin : aux_level[9];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.state <= ddo_pkg::DDO_ST_STRAP;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Three channels with staggered phase
    ddo_pwm_ch #(.PHASE(12'h000)) u_ch1 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .count(st_r.count),
        .duty(st_r.duty),
        .enable(pwm1_en),
        .pwm(pwm_w.out_1)
    );
    ddo_pwm_ch #(.PHASE(`DDO_PHASE_2)) u_ch2 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .count(st_r.count),
        .duty(st_r.duty),
        .enable(st_r.state == ddo_pkg::DDO_ST_RUN),
        .pwm(pwm_w.out_2)
    );
    ddo_pwm_ch #(.PHASE(`DDO_PHASE_3)) u_ch3 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .count(st_r.count),
        .duty(st_r.duty),
        .enable(st_r.state == ddo_pkg::DDO_ST_RUN),
        .pwm(pwm_w.out_3)
    );

    // Outputs straight from flip-flops, except analog_mode, which is the inverted mode bit
    assign pwm_out = pwm_w;
    assign status = '{analog_mode: !st_r.mode, analog_level: st_r.duty,
                      sync_active: st_r.sync_en};
    assign input_scaled = st_r.lvl;
    assign scale_external = st_r.scale_ext;
    assign progress_indicator = st_r.led;
    assign lux_data = st_r.lux_out;
    assign aux_state = st_r.aux;
    assign device_reset = st_r.dev_rst;
endmodule
`default_nettype wire

// ===== shared/ddo_cfg.svh
// Constants for the daylight dimming output block
`ifndef DDO_CFG_SVH
`define DDO_CFG_SVH
`define DDO_CLK_HZ 25000000
`define DDO_PWM_HZ 888
// Rounded to nearest so the period lands closest to the nominal rate
`define DDO_PWM_PERIOD ((`DDO_CLK_HZ + `DDO_PWM_HZ * 2048) / (`DDO_PWM_HZ * 4096))
`define DDO_RESET_MS 100
`define DDO_RESET_CYC (`DDO_CLK_HZ / 1000 * `DDO_RESET_MS)
`define DDO_SYNC_IDLE_CYC (`DDO_RESET_CYC / 4)
`define DDO_PHASE_2 12'h555
`define DDO_PHASE_3 12'hAAA
`define DDO_DUTY_W 12
`define DDO_LVL_W 10
`define DDO_LUX_W 16
`endif

// ===== shared/ddo_pkg.sv
// Types for the daylight dimming output block
package ddo_pkg;
    typedef enum logic [2:0] {
        DDO_ST_STRAP = 3'h1,
        DDO_ST_RUN = 3'h2,
        DDO_ST_RESET = 3'h4
    } ddo_state_type;
    typedef struct packed {
        logic out_1;
        logic out_2;
        logic out_3;
    } ddo_pwm_type;
    typedef struct packed {
        logic analog_mode;
        logic [11:0] analog_level;
        logic sync_active;
    } ddo_stat_type;
endpackage

// ===== hw/ddo_pwm_ch.sv
// One pwm channel comparing a shifted phase against duty
`timescale 1ns/1ps
`default_nettype none
`include "ddo_cfg.svh"
module ddo_pwm_ch #(
    parameter logic [11:0] PHASE = 12'h000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] count,
    input wire logic [11:0] duty,
    input wire logic enable,
    output logic pwm
);
    typedef struct packed {
        logic pwm;
    } ddo_ch_state_type;
    ddo_ch_state_type st_r;
    ddo_ch_state_type st_nxt;
    logic [11:0] shifted;

    // Shifted phase staggers the rising edges of the channels
    always_comb begin
        shifted = count + PHASE;
        st_nxt = st_r;
        if (!enable) begin
            st_nxt.pwm = 1'b0;
        end else if (duty == 12'hFFF) begin
            st_nxt.pwm = 1'b1; // Full on, 100 percent
        end else begin
            st_nxt.pwm = (shifted < duty);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign pwm = st_r.pwm;
endmodule
`default_nettype wire

// ===== test/ddo_props.sv
// Port checks for the dimming output block
`timescale 1ns/1ps
`default_nettype none
module ddo_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hv_supply_high,
    input wire logic prog_active,
    input wire logic sync_or_reset_pin,
    input wire logic [15:0] lux_result,
    input wire logic lux_done,
    input wire logic lux_read,
    input wire ddo_pkg::ddo_pwm_type pwm_out,
    input wire ddo_pkg::ddo_stat_type status,
    input wire logic [9:0] input_scaled,
    input wire logic scale_external,
    input wire logic progress_indicator,
    input wire logic [15:0] lux_data,
    input wire logic device_reset
);
    // One domain; past reset guards the first edge after release
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_scale;
        $past(rst_n) |-> scale_external == !$past(hv_supply_high); endproperty
    a_scale: assert property (p_scale) else $error("scale");
    property p_prog;
        $past(rst_n) |-> progress_indicator == $past(prog_active); endproperty
    a_prog: assert property (p_prog) else $error("indicator");
    property p_rst_in;
        $rose(device_reset) |-> !$past(sync_or_reset_pin); endproperty
    a_rst_in: assert property (p_rst_in) else $error("reset");
    property p_rst_out; sync_or_reset_pin [*4] |=> !device_reset; endproperty
    a_rst_out: assert property (p_rst_out) else $error("stuck");
    // Hold is loaded on done, published one cycle later if the reader is idle
    property p_lux;
        lux_done ##1 !lux_read |=> lux_data == $past(lux_result, 2);
    endproperty
    a_lux: assert property (p_lux) else $error("publish");
    property p_hold; lux_read |=> $stable(lux_data); endproperty
    a_hold: assert property (p_hold) else $error("torn");
    property p_ana; status.analog_mode |-> !pwm_out.out_1; endproperty
    a_ana: assert property (p_ana) else $error("out1");
    property p_duty; (!device_reset && $stable(input_scaled)) [*3] |->
        status.analog_level == {input_scaled, input_scaled[9:8]}; endproperty
    a_duty: assert property (p_duty) else $error("duty");
endmodule
`default_nettype wire

// ===== test/ddo_ballast_model.sv
// Ballast stage model that integrates pwm on-time
`timescale 1ns/1ps
`default_nettype none
module ddo_ballast_model (
    input wire logic clk_sys,
    input wire logic clr,
    input wire ddo_pkg::ddo_pwm_type pwm,
    output logic [15:0] on_1,
    output logic [15:0] on_2,
    output logic [15:0] on_3
);
    // Light follows on-time of all three pwm channels
    always_ff @(posedge clk_sys) begin
        on_1 <= clr ? 16'h0000 : on_1 + 16'(pwm.out_1);
        on_2 <= clr ? 16'h0000 : on_2 + 16'(pwm.out_2);
        on_3 <= clr ? 16'h0000 : on_3 + 16'(pwm.out_3);
    end
endmodule
`default_nettype wire

// ===== test/tb_daylight_dimming_output.sv
// Bench for the daylight dimming output block
`timescale 1ns/1ps
`default_nettype none
module tb_daylight_dimming_output;
    logic [9:0] dim_level_input = 10'h200, cmd_level = 10'h155;
    logic [9:0] aux_level = 10'h000, input_scaled;
    logic [15:0] lux_result = 16'hA5C3, lux_data, on_1, on_2, on_3;
    logic clk_sys = 1'h0, rst_n = 1'h0, clr = 1'h1, hv_supply_high = 1'h1;
    logic mode_strap = 1'h1, sync_or_reset_pin = 1'h1, aux_pin = 1'h1;
    logic cmd_level_valid = 1'h0, cmd_select = 1'h0, prog_active = 1'h0;
    logic lux_done = 1'h0, lux_read = 1'h1, aux_digital_mode = 1'h1;
    logic scale_external, progress_indicator, aux_state, device_reset;
    ddo_pkg::ddo_pwm_type pwm_out;
    ddo_pkg::ddo_stat_type status;
    int num_errors = 0, samples_checked = 0;
    wire logic [47:0] view = {lux_data, 4'h0, status.analog_level, 10'h000,
        status.analog_mode, status.sync_active, aux_state, scale_external,
        progress_indicator, device_reset};
    // Short reset count keeps the run brief
    ddo_dimming_out #(.RESET_CYC(50), .SYNC_IDLE_CYC(20)) dut (.*);
    ddo_ballast_model lamp (.clk_sys(clk_sys), .clr(clr), .pwm(pwm_out),
        .on_1(on_1), .on_2(on_2), .on_3(on_3));
    initial forever #20 clk_sys = ~clk_sys;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Sampling 1 ns late lets the edge updates land
    task automatic look(input int n);
        tick(n);
        #1;
    endtask
    task automatic check(input string s, input logic [47:0] e, g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic end_of_test(input int extra);
        num_errors += extra;
        $display("checked %0d bad %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard, some 13 percent past the expected run
    initial #1300000 end_of_test(1);
    // Sequence; one pwm period is 4096 x 7 clocks
    initial begin
        tick(8);
        rst_n <= 1'h1;
        look(8);
        check("boot", 48'h0000_0802_0008, view);
        tick(1);
        clr <= 1'h0;
        look(28672);
        check("on", 48'h380E_380E_380E, {on_1, on_2, on_3});
        tick(1);
        {cmd_level_valid, cmd_select, hv_supply_high, lux_done} <= 4'hD;
        {prog_active, aux_digital_mode, aux_level} <= 12'hA00;
        tick(1);
        {cmd_level_valid, lux_done, cmd_level} <= 12'h0AA;
        look(4);
        check("cmd", 48'h0000_0555_000E, view);
        tick(1);
        {hv_supply_high, lux_read, prog_active, aux_level} <= 13'h11FF;
        look(4);
        check("lux", 48'hA5C3_0555_0000, view);
        // New result while the reader is idle is published two edges on
        tick(1);
        {lux_done, lux_result} <= 17'h13C5A;
        tick(1);
        lux_done <= 1'h0;
        look(3);
        check("lux2", 48'h3C5A, 48'(lux_data));
        tick(1);
        {sync_or_reset_pin, mode_strap} <= 2'h0;
        look(40);
        check("early", 48'h0, 48'(device_reset));
        look(20);
        check("dreset", 48'h1, 48'(device_reset));
        tick(1);
        sync_or_reset_pin <= 1'h1;
        look(6);
        check("remode", 48'h20, view & 48'hEF);
        tick(1);
        mode_strap <= 1'h1;
        look(4);
        check("keep", 48'h20, view & 48'hEF);
        end_of_test(0);
    end
endmodule
bind ddo_dimming_out ddo_props u_props (.*);
`default_nettype wire
